// ===== core/wdep_cfg.svh
// constants for the watchdog unit with init-end write protection
// Behaviour
// - 16-bit up-counter; user reload in normal mode, fixed reload otherwise.
// - counter ticks at system clock divided by 256 or 16384.
// - main control changes need password write then modify write.
// - gap between password and modify write is timed; overlong gap fails.
// - wrong password or wrong guard bits flag access error, start reset.
// - counter overflow before service flags overflow error, start reset.
// - disabling stops only service need; access checks and lock monitor stay.
// - two watchdog resets without proper access between hold reset until power-on.
// - error raises NMI request first, system reset after fixed delay.
// - protection line follows lock bit; writes need lock 0 and supervisor.
// - blocked protected write gives bus error, register unchanged.
// - clearing the lock bit starts a time-out sequence.
// - time-out expiry before lock set back to 1 resets the system.
// - clock control, vector bases, stack pointer, secondary control are protected.
// - secondary control values act only once lock is set back to 1.
// - after reset start in time-out mode with slow clock division.
// - successful password write enters time-out mode.
// - proper time-out exit goes normal if disable request 0, else disabled.
// - valid service in normal mode reloads user start value.
`ifndef WDEP_CFG_SVH
`define WDEP_CFG_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define WD_OFF_CON0       8'h00
`define WD_OFF_CON1       8'h04
`define WD_OFF_STATUS     8'h08
`define WD_OFF_CLKCTL     8'h10
`define WD_OFF_TRAPVEC    8'h14
`define WD_OFF_INTVEC     8'h18
`define WD_OFF_ISTACK     8'h1C

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define WD_C0_LOCK        0
`define WD_C0_GUARD       1
`define WD_C0_PW_LO       8
`define WD_C0_PW_HI       15
`define WD_C0_REL_LO      16
`define WD_C0_REL_HI      31
`define WD_C1_FAST        2
`define WD_C1_DIS         3
`define WD_SR_AE          0
`define WD_SR_OE          1
`define WD_SR_FAST        2
`define WD_SR_DS          3
`define WD_SR_TO          4
`define WD_SR_PR          5
`define WD_SR_CNT_LO      16

// ---------------------------------------------------------------
// reset values and fixed codes
// ---------------------------------------------------------------
`define WD_PASSWORD       8'h5A
`define WD_TO_RELOAD      16'hFFFC
`define WD_REL_RESET      16'hFFFC
`define WD_PROT_RESET     32'h0000_0000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define WD_DIV_FAST       256
`define WD_DIV_SLOW       16384
`define WD_CLK_PERIOD_NS  10
`define WD_ACCESS_GAP_NS  5000
`define WD_ACCESS_GAP_CYC (`WD_ACCESS_GAP_NS / `WD_CLK_PERIOD_NS)
`define WD_PREWARN_NS     81920
`define WD_PREWARN_CYC    (`WD_PREWARN_NS / `WD_CLK_PERIOD_NS)
`define WD_RST_PULSE_CYC  16

`endif

// ===== core/wdep_pkg.sv
// types shared by the watchdog unit files
package wdep_pkg;

   // operating modes of the watchdog
   typedef enum logic [1:0] {
      MD_TIMEOUT,
      MD_NORMAL,
      MD_DISABLED,
      MD_PREWARN
   } wdep_mode_t;

endpackage

// ===== core/wdep_watchdog_unit.sv
// watchdog unit with init-end lock, protected registers and wishbone slave
//
// Local design decisions: the Wishbone register port and the placing of the registers.
`timescale 1ns/100ps
`include "wdep_cfg.svh"
module wdep_watchdog_unit #(
   parameter int PREWARN_CYCLES = `WD_PREWARN_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        por_i,
   input  wire logic        supervisor_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             wb_err_o,
   output logic             init_end_lock_bit_o,
   output logic             prewarn_nmi_request_o,
   output logic             sys_reset_o,
   output logic             reset_hold_o,
   output logic      [31:0] clk_ctl_o,
   output logic      [31:0] trap_vector_base_o,
   output logic      [31:0] interrupt_vector_base_o,
   output logic      [31:0] interrupt_stack_pointer_o
);
   import wdep_pkg::*;

   localparam logic [15:0] GAP_LAST  = 16'(`WD_ACCESS_GAP_CYC - 1);
   localparam logic [15:0] PRE_LAST  = 16'(PREWARN_CYCLES - 1);
   localparam logic [4:0]  RST_LAST  = 5'(`WD_RST_PULSE_CYC - 1);

   wdep_mode_t  mode;
   wdep_mode_t  next_mode;
   logic        con0_open;
   logic [15:0] gap_cnt;
   logic [15:0] user_reload;
   logic        c1_fast_req;
   logic        c1_dis_req;
   logic        fast_act;
   logic        acc_err;
   logic        ovf_err;
   logic [15:0] pre_cnt;
   logic        rst_issued;
   logic        dbl_armed;
   logic [4:0]  rst_cnt;
   wire  [15:0] wd_count;
   wire         wd_ovf;

   // ---------------------------------------------------------------
   // bus request decode
   // ---------------------------------------------------------------
   wire        req     = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   wire [7:0]  adr_w   = {wb_adr_i[7:2], 2'b00};
   wire        wr      = req && wb_we_i;
   wire        hit_c0  = (adr_w == `WD_OFF_CON0);
   wire        hit_c1  = (adr_w == `WD_OFF_CON1);
   wire        hit_sr  = (adr_w == `WD_OFF_STATUS);
   wire        hit_clk = (adr_w == `WD_OFF_CLKCTL);
   wire        hit_tv  = (adr_w == `WD_OFF_TRAPVEC);
   wire        hit_iv  = (adr_w == `WD_OFF_INTVEC);
   wire        hit_is  = (adr_w == `WD_OFF_ISTACK);
   wire        hit_prot = hit_c1 || hit_clk || hit_tv || hit_iv || hit_is;
   // protected registers open only with lock clear and supervisor active
   wire        prot_open = !init_end_lock_bit_o && supervisor_i;
   wire        prot_wr   = wr && hit_prot && prot_open;
   wire        prot_bad  = wr && hit_prot && !prot_open;

   // byte lane mask for the plain registers
   wire [31:0] lane_mask;
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign lane_mask[gi*8 +: 8] = {8{wb_sel_i[gi]}};
      end
   endgenerate

   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input logic [31:0] mask);
      merge = (old_v & ~mask) | (new_v & mask);
   endfunction

   // ---------------------------------------------------------------
   // password and guard checks on the main control register
   // ---------------------------------------------------------------
   // the password field is checked on both writes; guard bit must read
   // locked on the first write and unlocked on the second
   wire c0_wr    = wr && hit_c0;
   wire live     = (mode != MD_PREWARN);                   // prewarning cannot be altered
   wire pw_hit   = (wb_dat_i[`WD_C0_PW_HI:`WD_C0_PW_LO] == `WD_PASSWORD);
   wire pw_ok    = c0_wr && live && !con0_open && pw_hit && wb_dat_i[`WD_C0_GUARD];
   wire mod_ok   = c0_wr && live && con0_open && pw_hit && !wb_dat_i[`WD_C0_GUARD];
   wire new_lock = wb_dat_i[`WD_C0_LOCK];
   wire gap_exp  = con0_open && live && !c0_wr && (gap_cnt == GAP_LAST);
   wire acc_fail = (c0_wr && live && !pw_ok && !mod_ok) || gap_exp;
   wire ovf_fail = wd_ovf && ((mode == MD_TIMEOUT) || (mode == MD_NORMAL));
   wire err_evt  = acc_fail || ovf_fail;
   wire lock_set = mod_ok && new_lock;

   // ---------------------------------------------------------------
   // mode transitions
   // ---------------------------------------------------------------
   always_comb begin
      next_mode = mode;
      if (err_evt) begin
         next_mode = MD_PREWARN;
      end else if (pw_ok) begin
         next_mode = MD_TIMEOUT;
      end else if (lock_set) begin
         next_mode = c1_dis_req ? MD_DISABLED : MD_NORMAL;
      end else if (mod_ok) begin
         next_mode = MD_TIMEOUT;
      end
   end

   // counter reload on every mode change event
   wire        cnt_load = err_evt || pw_ok || mod_ok;
   wire        use_user = lock_set && !c1_dis_req;
   wire [15:0] load_val = use_user ? wb_dat_i[`WD_C0_REL_HI:`WD_C0_REL_LO]
                                   : `WD_TO_RELOAD;
   // disabled mode only stops the count; checks above still run
   wire        cnt_run  = (mode != MD_DISABLED);

   wdep_wd_counter u_counter (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .run_i      (cnt_run),
      .slow_i     (!fast_act),
      .load_i     (cnt_load),
      .load_val_i (load_val),
      .count_o    (wd_count),
      .ovf_o      (wd_ovf)
   );

   // mode register, time-out mode after system reset (rst_i); power-on alone leaves it
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mode <= MD_TIMEOUT;
      end else begin
         mode <= next_mode;
      end
   end

   // unlock window and gap timer between the two writes
   always_ff @(posedge clk_i) begin
      if (rst_i || err_evt || mod_ok) begin
         con0_open <= 1'b0;
         gap_cnt   <= 16'h0000;
      end else if (pw_ok) begin
         con0_open <= 1'b1;
         gap_cnt   <= 16'h0000;
      end else if (con0_open) begin
         gap_cnt   <= gap_cnt + 16'h0001;
      end
   end

   // lock bit and user reload, written only by a modify access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         init_end_lock_bit_o <= 1'b0;
         user_reload         <= `WD_REL_RESET;
      end else if (mod_ok) begin
         init_end_lock_bit_o <= new_lock;
         user_reload         <= wb_dat_i[`WD_C0_REL_HI:`WD_C0_REL_LO];
      end
   end

   // secondary control requests; rate takes effect only at lock set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         c1_fast_req <= 1'b0;
         c1_dis_req  <= 1'b0;
         fast_act    <= 1'b0;
      end else begin
         if (prot_wr && hit_c1 && wb_sel_i[0]) begin
            c1_fast_req <= wb_dat_i[`WD_C1_FAST];
            c1_dis_req  <= wb_dat_i[`WD_C1_DIS];
         end
         if (lock_set) begin
            fast_act <= c1_fast_req;
         end
      end
   end

   // sticky error flags, cleared only by reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_err <= 1'b0;
         ovf_err <= 1'b0;
      end else begin
         acc_err <= acc_err || acc_fail;
         ovf_err <= ovf_err || ovf_fail;
      end
   end

   // ---------------------------------------------------------------
   // prewarning: nmi first, reset request after fixed delay
   // ---------------------------------------------------------------
   wire issue_rst = (mode == MD_PREWARN) && !rst_issued && (pre_cnt == PRE_LAST);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prewarn_nmi_request_o <= 1'b0;
         pre_cnt               <= 16'h0000;
         rst_issued            <= 1'b0;
      end else begin
         prewarn_nmi_request_o <= prewarn_nmi_request_o || err_evt;
         if (mode == MD_PREWARN && !rst_issued) begin
            pre_cnt <= pre_cnt + 16'h0001;
         end
         rst_issued <= rst_issued || issue_rst;
      end
   end

   // reset pulse and double-reset hold survive system reset, cleared by power-on
   always_ff @(posedge clk_i) begin
      if (por_i) begin
         dbl_armed    <= 1'b0;
         reset_hold_o <= 1'b0;
         sys_reset_o  <= 1'b0;
         rst_cnt      <= 5'h00;
      end else if (issue_rst) begin
         dbl_armed    <= 1'b1;
         reset_hold_o <= reset_hold_o || dbl_armed;
         sys_reset_o  <= 1'b1;
         rst_cnt      <= 5'h00;
      end else begin
         if (mod_ok) begin
            dbl_armed <= 1'b0;
         end
         if (sys_reset_o && !reset_hold_o) begin
            rst_cnt     <= rst_cnt + 5'h01;
            sys_reset_o <= (rst_cnt != RST_LAST);
         end
      end
   end

   // ---------------------------------------------------------------
   // protected registers outside the watchdog
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_ctl_o                 <= `WD_PROT_RESET;
         trap_vector_base_o        <= `WD_PROT_RESET;
         interrupt_vector_base_o   <= `WD_PROT_RESET;
         interrupt_stack_pointer_o <= `WD_PROT_RESET;
      end else if (prot_wr) begin
         if (hit_clk) clk_ctl_o <= merge(clk_ctl_o, wb_dat_i, lane_mask);
         if (hit_tv)  trap_vector_base_o <= merge(trap_vector_base_o, wb_dat_i, lane_mask);
         if (hit_iv)  interrupt_vector_base_o <= merge(interrupt_vector_base_o, wb_dat_i, lane_mask);
         if (hit_is)  interrupt_stack_pointer_o <= merge(interrupt_stack_pointer_o, wb_dat_i, lane_mask);
      end
   end

   // ---------------------------------------------------------------
   // read mux and bus answer
   // ---------------------------------------------------------------
   wire [31:0] rd_c0 = {user_reload, 8'h00, 6'h00, !con0_open, init_end_lock_bit_o};
   wire [31:0] rd_c1 = {28'h0000000, c1_dis_req, c1_fast_req, 2'b00};
   wire [31:0] rd_sr = {wd_count, 10'h000, (mode == MD_PREWARN), (mode == MD_TIMEOUT),
                        (mode == MD_DISABLED), fast_act, ovf_err, acc_err};
   wire [31:0] rd_mux = hit_c0  ? rd_c0 :
                        hit_c1  ? rd_c1 :
                        hit_sr  ? rd_sr :
                        hit_clk ? clk_ctl_o :
                        hit_tv  ? trap_vector_base_o :
                        hit_iv  ? interrupt_vector_base_o :
                        hit_is  ? interrupt_stack_pointer_o : 32'h0000_0000;

   // one wait state; unmapped reads give zero, unmapped writes are dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_err_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req && !prot_bad;
         wb_err_o <= prot_bad;
         wb_dat_o <= (req && !wb_we_i) ? rd_mux : 32'h0000_0000;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   // password access taken, then the window stands open in time-out mode
   sequence s_pw_taken;
      pw_ok && !err_evt;
   endsequence

   sequence s_window_timeout;
      con0_open && (mode == MD_TIMEOUT);
   endsequence

   // a system reset also clears the lock, so the edge right after it is skipped
   a_lock_needs_unlock: assert property (@(posedge clk_i) disable iff (rst_i)
      (!$past(rst_i) && $changed(init_end_lock_bit_o)) |-> $past(con0_open))
      else $error("lock bit changed without password access");

   a_pw_enters_timeout: assert property (@(posedge clk_i) disable iff (rst_i)
      s_pw_taken |=> s_window_timeout)
      else $error("password access did not enter time-out mode");

   a_gap_expiry: assert property (@(posedge clk_i) disable iff (rst_i)
      (con0_open && live && !c0_wr && gap_cnt == GAP_LAST) |=> (acc_err && mode == MD_PREWARN))
      else $error("overlong access gap not treated as failure");

   a_bad_pw_error: assert property (@(posedge clk_i) disable iff (rst_i)
      (c0_wr && live && !con0_open && !pw_hit) |=> acc_err ##1 prewarn_nmi_request_o)
      else $error("wrong password did not flag access error");

   a_ovf_error: assert property (@(posedge clk_i) disable iff (rst_i)
      (wd_ovf && mode == MD_NORMAL) |=> (ovf_err && mode == MD_PREWARN))
      else $error("overflow in normal mode not flagged");

   a_disabled_holds: assert property (@(posedge clk_i) disable iff (rst_i)
      (mode == MD_DISABLED && !cnt_load) |=> $stable(wd_count))
      else $error("counter moved in disabled mode");

   a_nmi_before_rst: assert property (@(posedge clk_i) disable iff (rst_i)
      $rose(prewarn_nmi_request_o) |-> !sys_reset_o [*8])
      else $error("reset came without nmi delay");

   a_prot_blocked: assert property (@(posedge clk_i) disable iff (rst_i)
      (wr && hit_tv && init_end_lock_bit_o) |=> (wb_err_o && $stable(trap_vector_base_o)))
      else $error("protected write passed while locked");

   a_rate_at_lock: assert property (@(posedge clk_i) disable iff (rst_i)
      lock_set |=> (fast_act == $past(c1_fast_req)))
      else $error("rate request not applied at lock set");

   a_exit_mode: assert property (@(posedge clk_i) disable iff (rst_i)
      (lock_set && !err_evt) |=> (mode == ($past(c1_dis_req) ? MD_DISABLED : MD_NORMAL)))
      else $error("wrong mode after lock set");

   a_hold_until_por: assert property (@(posedge clk_i) disable iff (por_i)
      reset_hold_o |=> (reset_hold_o && sys_reset_o))
      else $error("reset hold released before power-on");

endmodule

// ===== core/wdep_wd_counter.sv
// prescaled 16-bit watchdog up-counter
`timescale 1ns/100ps
`include "wdep_cfg.svh"
module wdep_wd_counter (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        run_i,
   input  wire logic        slow_i,
   input  wire logic        load_i,
   input  wire logic [15:0] load_val_i,
   output logic      [15:0] count_o,
   output logic             ovf_o
);
   import wdep_pkg::*;

   localparam logic [13:0] PRE_FAST_MAX = 14'(`WD_DIV_FAST - 1);
   localparam logic [13:0] PRE_SLOW_MAX = 14'(`WD_DIV_SLOW - 1);

   logic [13:0] pre_cnt;
   wire  [13:0] pre_end;
   wire         tick;

   // ---------------------------------------------------------------
   // prescaler end select
   // ---------------------------------------------------------------
   // >= so a switch to the fast rate mid-period cannot skip a wrap
   assign pre_end = slow_i ? PRE_SLOW_MAX : PRE_FAST_MAX;
   assign tick    = run_i && (pre_cnt >= pre_end);

   // prescaler, restarted on every reload
   always_ff @(posedge clk_i) begin
      if (rst_i || load_i || tick) begin
         pre_cnt <= 14'h0000;
      end else if (run_i) begin
         pre_cnt <= pre_cnt + 14'h0001;
      end
   end

   // counter starts from the fixed time-out value after reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_o <= `WD_TO_RELOAD;
      end else if (load_i) begin
         count_o <= load_val_i;
      end else if (tick) begin
         count_o <= count_o + 16'h0001;
      end
   end

   // one-cycle overflow pulse on wrap from all ones
   always_ff @(posedge clk_i) begin
      if (rst_i || load_i) begin
         ovf_o <= 1'b0;
      end else begin
         ovf_o <= tick && (count_o == 16'hFFFF);
      end
   end

endmodule

// ===== sim/test_watchdog_init_end_lock_bit_protection.sv
// self-checking bench for the watchdog unit
`timescale 1ns/100ps
module test_watchdog_init_end_lock_bit_protection;
   localparam int PW = 32;
   logic        clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b1, sup_req = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [31:0] wdat = 32'h0, rd, dat_o, ctl_o, trap_o, ivec_o, isp_o;
   logic        ack, err, lock, nmi, srst, hold, sup;
   int          lead, fail_count = 0, samples_checked = 0;

   always #5 clk_i = ~clk_i;

   wdep_cpu_model cpu (.clk_i(clk_i), .sup_req_i(sup_req), .nmi_i(nmi),
      .sys_reset_i(srst), .supervisor_o(sup), .nmi_lead_o(lead));

   wdep_watchdog_unit #(.PREWARN_CYCLES(PW)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .por_i(por_i), .supervisor_i(sup), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
      .init_end_lock_bit_o(lock), .prewarn_nmi_request_o(nmi),
      .sys_reset_o(srst), .reset_hold_o(hold), .clk_ctl_o(ctl_o),
      .trap_vector_base_o(trap_o), .interrupt_vector_base_o(ivec_o),
      .interrupt_stack_pointer_o(isp_o));

   // ---------------------------------
   // compare and bus helpers
   // ---------------------------------
   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk32({31'h0, got}, {31'h0, exp});
   endtask

   // one classic cycle; request held until ack or err is sampled high at a rising edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic exp_err);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
      rd = dat_o;
      chk1(ack | err, 1'b1);
      chk1(err, exp_err);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // bounded wait for the nmi (0) or the system reset (1)
   task automatic wait_for(input bit which, input int lim);
      int n;
      n = 0;
      while ((which ? srst : nmi) !== 1'b1 && n < lim) begin
         @(negedge clk_i);
         n++;
      end
   endtask

   task automatic close_out;
      if (fail_count == 0 && samples_checked > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // main sequence: init, protection, lock set, overflow, double reset
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      por_i <= 1'b0;
      wb(0, 8'h08, 0, 0); chk32(rd, 32'hFFFC_0010);
      wb(0, 8'h00, 0, 0); chk32(rd, 32'hFFFC_0002);
      sup_req <= 1'b0;
      wb(1, 8'h10, 32'hA5, 1); chk32(ctl_o, 32'h0);
      sup_req <= 1'b1;
      wb(1, 8'h10, 32'hA5, 0); chk32(ctl_o, 32'hA5);
      wb(1, 8'h14, 32'h1234_5678, 0); chk32(trap_o, 32'h1234_5678);
      wb(1, 8'h1C, 32'hCAFE_0001, 0); chk32(isp_o, 32'hCAFE_0001);
      wb(1, 8'h04, 32'h4, 0);
      wb(0, 8'h08, 0, 0); chk32(rd & 32'h4, 32'h0);
      wb(1, 8'h00, 32'hFFFE_5A02, 0);
      wb(1, 8'h00, 32'hFFFE_5A01, 0); chk1(lock, 1'b1);
      wb(0, 8'h08, 0, 0); chk32(rd & 32'h3F, 32'h4);
      wb(1, 8'h18, 32'h1, 1); chk32(ivec_o, 32'h0);
      wb(1, 8'h14, 32'h1, 1); chk32(trap_o, 32'h1234_5678);
      wait_for(0, 2000); chk1(nmi, 1'b1); chk1(srst, 1'b0);
      wb(0, 8'h08, 0, 0); chk32(rd & 32'h23, 32'h22);
      wait_for(1, 2 * PW); chk1(srst, 1'b1);
      chk32(lead, PW);
      repeat (20) @(posedge clk_i);
      chk1(srst, 1'b0); chk1(hold, 1'b0);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(0, 8'h08, 0, 0); chk32(rd, 32'hFFFC_0010);
      wb(1, 8'h00, 32'hFFFC_1102, 0);
      wb(0, 8'h08, 0, 0); chk32(rd & 32'h21, 32'h21);
      wait_for(1, 4 * PW);
      repeat (40) @(posedge clk_i);
      chk1(srst, 1'b1); chk1(hold, 1'b1);
      por_i <= 1'b1;
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      por_i <= 1'b0;
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      chk1(srst, 1'b0); chk1(hold, 1'b0);
      // disabled mode stops the count, yet an overlong gap after a password access still fails
      wb(1, 8'h04, 32'h8, 0);
      wb(1, 8'h00, 32'hFFFC_5A02, 0);
      wb(1, 8'h00, 32'hFFFC_5A01, 0);
      wb(0, 8'h08, 0, 0); chk32(rd, 32'hFFFC_0008);
      wb(1, 8'h00, 32'hFFFC_5A02, 0);
      repeat (510) @(posedge clk_i);
      wb(0, 8'h08, 0, 0); chk32(rd, 32'hFFFC_0021);
      close_out;
   end

   // hang guard, well beyond the roughly 1200 cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      fail_count++;
      close_out;
   end
endmodule

// ===== sim/wdep_cpu_model.sv
// cpu side model: privilege level and nmi-to-reset timing
`timescale 1ns/100ps
module wdep_cpu_model (
   input  wire logic clk_i,
   input  wire logic sup_req_i,
   input  wire logic nmi_i,
   input  wire logic sys_reset_i,
   output logic      supervisor_o,
   output int        nmi_lead_o
);
   // mode switch lands a cycle late, as a real privilege change would
   always_ff @(posedge clk_i) begin
      supervisor_o <= sup_req_i;
      if (nmi_i !== 1'b1)
         nmi_lead_o <= 0;
      else if (sys_reset_i !== 1'b1)
         nmi_lead_o <= nmi_lead_o + 1;
   end
endmodule
